// >>> shared/dcpo_pkg.sv
// dcpo_pkg: register map, field layout, mode codes and reset values
// for the dual compare pulse output block; assumes 32-bit apb data.
`default_nettype none
package dcpo_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRI = 8'h04;
  localparam logic [7:0] OFS_SEC = 8'h08;
  localparam logic [7:0] OFS_TBCTRL = 8'h0C;
  localparam logic [7:0] OFS_PERIOD = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1C;
  // ****************************************
  // field positions
  // ****************************************
  localparam int MODE_LSB = 0;
  localparam int TBSEL_BIT = 3;
  localparam int CH_ON_BIT = 15;
  localparam int TB_ON_BIT = 15;
  localparam int ST_FALL_BIT = 0;
  localparam int ST_RISE_BIT = 1;
  // ****************************************
  // mode codes
  // ****************************************
  typedef enum logic [2:0] {
    DCPO_MODE_OFF = 3'b000,
    DCPO_MODE_SINGLE = 3'b100,
    DCPO_MODE_CONT = 3'b101
  } dcpo_mode_t;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_CMP = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [1:0] RST_FLAGS = 2'h0;
endpackage
`default_nettype wire

// >>> src/dcpo_timebase.sv
// dcpo_timebase: one 16-bit up counter with period wrap and software load.
// assumes writes and enable come from the register slave in the same clock.
`timescale 1ns/10ps
`default_nettype none
module dcpo_timebase
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [15:0] period,
  input wire logic load,
  input wire logic [15:0] load_val,
  output logic [15:0] count,
  output logic wrap
);
  // wrap marks the cycle in which the count returns to zero [R5]
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count <= dcpo_pkg::RST_COUNT;
      wrap <= 1'b0;
    end
    else if (load)
    begin
      count <= load_val;
      wrap <= 1'b0;
    end
    else if (run && count >= period)
    begin
      count <= 16'h0000; // [R5]
      wrap <= 1'b1;
    end
    else if (run)
    begin
      count <= count + 16'h0001;
      wrap <= 1'b0;
    end
    else
    begin
      wrap <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> src/dcpo_top.sv
// dcpo_top: dual compare output channel with two selectable time bases,
// apb register slave and one masked level interrupt.
// assumes psel/penable follow apb and all inputs are synchronous to CLK.
//
// Functional notes
// [R1] continuous mode: low until primary match
// [R2] rise one clock after primary match; the pin rises three clocks after it
// [R3] stay high until secondary match, then fall
// [R4] continuous pulses repeat every period
// [R5] time base wraps to zero after period
// [R6] secondary above period: no fall
// [R7] flag set on every secondary falling edge
// [R8] single pulse may fall after wrap
// [R9] secondary above period: rise only, no flag; the code still sets the rise flag, status bit 1
// [R10] primary above period: output stays low
// [R11] primary zero at start: delayed one period
// [R12] software sets rise, fall and period
// [R13] software writes mode and time base select
// [R14] software starts time base after setup
// [R15] mode 100 gives exactly one pulse
// [R16] rewriting single mode rearms pulse
// [R17] disable or mode change forces output low
`timescale 1ns/10ps
`default_nettype none
module dcpo_top
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic COMPARE_OUTPUT_PIN,
  output logic IRQ
);
  // ****************************************
  // registers
  // ****************************************
  logic [15:0] ctrl_r;
  logic [15:0] pri_r;
  logic [15:0] sec_r;
  logic [1:0] tb_on_r;
  logic [15:0] period_r [2];
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic [15:0] count [2];
  logic [1:0] cnt_load;
  logic [1:0] tb_wr;
  logic [1:0] per_wr;
  logic [1:0] cnt_wr;
  logic tb_sel;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic ctrl_wr;
  logic [31:0] rd_nxt;
  logic [15:0] tb_count;
  logic tb_run;
  logic ch_on;
  dcpo_pkg::dcpo_mode_t mode;
  logic pri_match;
  logic sec_match;
  logic lvl_r;
  logic adv_r;
  logic mode_ok;
  logic done_r;
  logic out_r;
  logic fall_evt;
  logic rise_evt;

  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  assign ctrl_wr = wr_en && PADDR == dcpo_pkg::OFS_CTRL;
  assign tb_sel = ctrl_r[dcpo_pkg::TBSEL_BIT];
  assign ch_on = ctrl_r[dcpo_pkg::CH_ON_BIT];
  assign mode = dcpo_pkg::dcpo_mode_t'(ctrl_r[dcpo_pkg::MODE_LSB +: 3]);
  assign tb_count = count[tb_sel];
  assign tb_run = tb_on_r[tb_sel];
  // PWDATA bit 16 selects time base 0 or 1 on writes to TBCTRL/PERIOD/COUNT
  assign addr_ok = PADDR[1:0] == 2'b00 && PADDR <= dcpo_pkg::OFS_MASK;

  // ****************************************
  // time bases
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_tb
      assign tb_wr[g] = wr_en && PADDR == dcpo_pkg::OFS_TBCTRL && PWDATA[16] == 1'(g);
      assign per_wr[g] = wr_en && PADDR == dcpo_pkg::OFS_PERIOD && PWDATA[16] == 1'(g);
      assign cnt_wr[g] = wr_en && PADDR == dcpo_pkg::OFS_COUNT && PWDATA[16] == 1'(g);
      assign cnt_load[g] = cnt_wr[g];
      always_ff @(posedge CLK)
      begin
        if (RST)
        begin
          tb_on_r[g] <= 1'b0;
          period_r[g] <= dcpo_pkg::RST_PERIOD;
        end
        else
        begin
          if (tb_wr[g])
          begin
            tb_on_r[g] <= PWDATA[dcpo_pkg::TB_ON_BIT]; // [R14]
          end
          if (per_wr[g])
          begin
            period_r[g] <= PWDATA[15:0];
          end
        end
      end
      dcpo_timebase u_tb
      (
        .clk(CLK),
        .rst(RST),
        .run(tb_on_r[g]),
        .period(period_r[g]),
        .load(cnt_load[g]),
        .load_val(PWDATA[15:0]),
        .count(count[g]),
        .wrap()
      );
    end
  endgenerate

  // ****************************************
  // control and compare registers
  // ****************************************
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctrl_r <= dcpo_pkg::RST_CTRL;
      pri_r <= dcpo_pkg::RST_CMP;
      sec_r <= dcpo_pkg::RST_CMP;
      mask_r <= dcpo_pkg::RST_FLAGS;
    end
    else if (wr_en)
    begin
      case (PADDR)
        dcpo_pkg::OFS_CTRL: ctrl_r <= PWDATA[15:0]; // [R13]
        dcpo_pkg::OFS_PRI: pri_r <= PWDATA[15:0]; // [R12]
        dcpo_pkg::OFS_SEC: sec_r <= PWDATA[15:0]; // [R12]
        dcpo_pkg::OFS_MASK: mask_r <= PWDATA[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // pulse engine
  // ****************************************
  // a value only matches once the running count has stepped onto it, so a
  // primary of 0 with the count started at 0 waits one full period [R11]
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      adv_r <= 1'b0;
    end
    else
    begin
      adv_r <= tb_run && !cnt_load[tb_sel]; // [R11]
    end
  end

  // a primary value above the period simply never matches, so the pin stays low [R10]
  assign mode_ok = ch_on && (mode == dcpo_pkg::DCPO_MODE_SINGLE ||
                             mode == dcpo_pkg::DCPO_MODE_CONT);
  assign pri_match = tb_run && adv_r && tb_count == pri_r;
  assign sec_match = tb_run && adv_r && tb_count == sec_r;
  assign rise_evt = mode_ok && !ctrl_wr && pri_match && !lvl_r && !done_r; // [R1]
  assign fall_evt = mode_ok && !ctrl_wr && sec_match && lvl_r; // [R7]

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      out_r <= 1'b0;
      lvl_r <= 1'b0;
      done_r <= 1'b0;
    end
    else if (ctrl_wr || !mode_ok)
    begin
      // any control write rearms the channel and drives low [R17] [R16]
      out_r <= 1'b0;
      lvl_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      // both edges pass the same two extra registers, out_r and the pin register, so the pin rises three clocks
      // after the primary match and stays high secondary minus primary clocks, period plus one more if the secondary is below the primary
      out_r <= lvl_r; // [R2] [R4]
      if (rise_evt)
      begin
        lvl_r <= 1'b1; // [R1] [R2]
      end
      else if (fall_evt)
      begin
        // a secondary beyond the period never matches: high holds [R6] [R9]
        lvl_r <= 1'b0; // [R3] [R8]
        done_r <= mode == dcpo_pkg::DCPO_MODE_SINGLE; // [R15] [R4]
      end
    end
  end

  // ****************************************
  // interrupt status, cleared by reading it
  // ****************************************
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      status_r <= dcpo_pkg::RST_FLAGS;
    end
    else
    begin
      // a new event in the clearing cycle wins over the read clear
      if (rd_en && PADDR == dcpo_pkg::OFS_STATUS)
      begin
        status_r <= {rise_evt, fall_evt};
      end
      else
      begin
        status_r <= status_r | {rise_evt, fall_evt}; // [R7]
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      IRQ <= 1'b0;
      COMPARE_OUTPUT_PIN <= 1'b0;
    end
    else
    begin
      IRQ <= |(status_r & mask_r);
      COMPARE_OUTPUT_PIN <= out_r;
    end
  end

  // ****************************************
  // apb read and response
  // ****************************************
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (PADDR)
      dcpo_pkg::OFS_CTRL: rd_nxt = {16'h0000, ctrl_r};
      dcpo_pkg::OFS_PRI: rd_nxt = {16'h0000, pri_r};
      dcpo_pkg::OFS_SEC: rd_nxt = {16'h0000, sec_r};
      dcpo_pkg::OFS_TBCTRL: rd_nxt = {14'h0000, tb_on_r, 16'h0000};
      dcpo_pkg::OFS_PERIOD: rd_nxt = {period_r[1], period_r[0]};
      dcpo_pkg::OFS_COUNT: rd_nxt = {count[1], count[0]};
      dcpo_pkg::OFS_STATUS: rd_nxt = {29'h0000_0000, out_r, status_r};
      dcpo_pkg::OFS_MASK: rd_nxt = {30'h0000_0000, mask_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // no wait state: the answer registers in the setup cycle and is ready in the first access cycle
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= PSEL && !PENABLE;
      PRDATA <= (PSEL && !PENABLE && !PWRITE) ? rd_nxt : 32'h0000_0000;
      PSLVERR <= PSEL && !PENABLE && !addr_ok;
    end
  end
endmodule
`default_nettype wire

// >>> test/dcpo_pin_monitor.sv
// dcpo_pin_monitor: load on the compare output pin that counts edges
// and records the last high width and the spacing of rising edges in clocks.
// assumes one clock shared with the channel.
`timescale 1ns/10ps
`default_nettype none
module dcpo_pin_monitor
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output int rises,
  output int falls,
  output int width,
  output int gap
);
  // ****
  // edge timing
  // ****
  int cyc;
  int t_rise;
  logic pin_d;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cyc <= 0;
      t_rise <= 0;
      pin_d <= 1'b0;
      rises <= 0;
      falls <= 0;
      width <= 0;
      gap <= 0;
    end
    else
    begin
      cyc <= cyc + 1;
      pin_d <= pin;
      if (pin && !pin_d)
      begin
        rises <= rises + 1;
        gap <= cyc - t_rise;
        t_rise <= cyc;
      end
      if (!pin && pin_d)
      begin
        falls <= falls + 1;
        width <= cyc - t_rise;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/dcpo_top_properties.sv
// dcpo_top_properties: port-level checks of the compare channel.
// assumes an apb master and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module dcpo_top_properties
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic COMPARE_OUTPUT_PIN,
  input wire logic IRQ
);
  // ****
  // properties
  // ****
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic bad_a;
  assign bad_a = PADDR > dcpo_pkg::OFS_MASK || PADDR[1:0] != 2'h0;
  property p_rdy; PSEL && !PENABLE |=> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_pulse; PREADY |=> !PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_errr; PSLVERR |-> PREADY; endproperty
  a_errr: assert property (p_errr) else $error("error without ready");
  property p_bad; PSEL && !PENABLE && bad_a |=> PSLVERR; endproperty
  a_bad: assert property (p_bad) else $error("unmapped address accepted");
  property p_good; PSEL && !PENABLE && !bad_a |=> !PSLVERR; endproperty
  a_good: assert property (p_good) else $error("mapped address refused");
  property p_idle; !PREADY |-> PRDATA == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  // the force low lands in the pin register one clock after the write edge
  property p_off; PSEL && PENABLE && PWRITE && PADDR == 8'h00 |-> ##2 !COMPARE_OUTPUT_PIN;
  endproperty
  a_off: assert property (p_off) else $error("pin high after control write");
  property p_rst; $fell(RST) |-> !COMPARE_OUTPUT_PIN && !IRQ && !PREADY; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  c_rise: cover property ($rose(COMPARE_OUTPUT_PIN));
  c_fall: cover property ($fell(COMPARE_OUTPUT_PIN));
  c_irq: cover property ($rose(IRQ));
endmodule
bind dcpo_top dcpo_top_properties u_dcpo_top_properties (.CLK(CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .COMPARE_OUTPUT_PIN(COMPARE_OUTPUT_PIN), .IRQ(IRQ));
`default_nettype wire

// >>> test/testbench.sv
// testbench: drives the channel over apb and judges pulse timing seen
// by the pin monitor against widths worked out from the compare values.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ****
  // bench
  // ****
  logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, PIN, IRQ, e;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q, lf;
  int fail_count, num_checks, rises, falls, width, gap, r0, f0, pri, sec, per;
  dcpo_top u_dcpo_top (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .COMPARE_OUTPUT_PIN(PIN), .IRQ(IRQ));
  dcpo_pin_monitor u_dcpo_pin_monitor (.clk(CLK), .rst(RST), .pin(PIN), .rises(rises),
    .falls(falls), .width(width), .gap(gap));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial
  begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLK);
    end
    while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // software order: stop, clear flags, load values, arm mode, then start timer
  task automatic run(input logic [2:0] m, input int p1, p2, pr, wt);
    apb(1'b1, dcpo_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, dcpo_pkg::OFS_TBCTRL, 32'h0);
    apb(1'b0, dcpo_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, dcpo_pkg::OFS_PRI, p1);
    apb(1'b1, dcpo_pkg::OFS_SEC, p2);
    apb(1'b1, dcpo_pkg::OFS_PERIOD, pr);
    apb(1'b1, dcpo_pkg::OFS_COUNT, 32'h0);
    apb(1'b1, dcpo_pkg::OFS_CTRL, {16'h0, 13'h1000, m});
    r0 = rises;
    f0 = falls;
    apb(1'b1, dcpo_pkg::OFS_TBCTRL, 32'h0000_8000);
    repeat (wt) @(posedge CLK);
  endtask
  initial
  begin
    repeat (5000) @(posedge CLK);
    fail_count++;
    complete_run;
  end
  initial
  begin
    {RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {4'h8, 8'h0, 32'h0};
    lf = 32'h0000_afea;
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b0, dcpo_pkg::OFS_PERIOD, 32'h0);
    chk(q, {2{dcpo_pkg::RST_PERIOD}});
    apb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0000_0000);
    chk(e, 1'b1);
    apb(1'b1, dcpo_pkg::OFS_MASK, 32'h1);
    repeat (3)
    begin
      lf = lfsr(lf);
      pri = 1 + lf[2:0];
      sec = pri + 1 + lf[5:3];
      per = sec + lf[8:6];
      run(dcpo_pkg::DCPO_MODE_CONT, pri, sec, per, 3 * (per + 1) + pri + 8);
      chk(width, sec - pri);
      chk(gap, per + 1);
      chk(falls - f0 >= 2, 1);
      chk(IRQ, 1);
      apb(1'b0, dcpo_pkg::OFS_STATUS, 32'h0);
      chk(q[0], 1);
      $display("test done: continuous");
    end
    apb(1'b1, dcpo_pkg::OFS_CTRL, 32'h0);
    r0 = rises;
    apb(1'b0, dcpo_pkg::OFS_STATUS, 32'h0);
    repeat (50) @(posedge CLK);
    chk(rises - r0, 0);
    chk(PIN, 1'b0);
    chk(IRQ, 1'b0);
    run(dcpo_pkg::DCPO_MODE_SINGLE, 5, 2, 9, 40);
    chk(rises - r0, 1);
    chk(falls - f0, 1);
    chk(width, 9 - 5 + 1 + 2);
    r0 = rises;
    apb(1'b1, dcpo_pkg::OFS_CTRL, 32'h0000_8004);
    repeat (30) @(posedge CLK);
    chk(rises - r0, 1);
    $display("test done: single");
    run(dcpo_pkg::DCPO_MODE_SINGLE, 3, 20, 10, 40);
    apb(1'b0, dcpo_pkg::OFS_STATUS, 32'h0);
    chk(rises - r0, 1);
    chk(falls - f0, 0);
    chk(q[0], 1'b0);
    chk(q[1], 1'b1);
    run(dcpo_pkg::DCPO_MODE_CONT, 3, 20, 10, 40);
    chk(rises - r0, 1);
    chk(falls - f0, 0);
    chk(PIN, 1'b1);
    run(dcpo_pkg::DCPO_MODE_CONT, 12, 14, 10, 40);
    chk(rises - r0, 0);
    chk(PIN, 1'b0);
    run(dcpo_pkg::DCPO_MODE_SINGLE, 0, 4, 6, 5);
    chk(rises - r0, 0);
    repeat (12) @(posedge CLK);
    chk(rises - r0, 1);
    $display("test done: boundaries");
    complete_run;
  end
endmodule
`default_nettype wire
